// ### hbd_pkg.sv
package hbd_pkg;
    // Clock and bus geometry
    localparam int          CLK_PERIOD_NS = 20;
    localparam int          ADDR_W        = 8;
    localparam int          DATA_W        = 32;
    localparam logic [1:0]  RESP_OKAY     = 2'h0;
    localparam logic [1:0]  RESP_SLVERR   = 2'h2;

    // Register offsets (byte addresses)
    localparam logic [7:0]  REG_CTRL      = 8'h00;
    localparam logic [7:0]  REG_DUTY      = 8'h04;
    localparam logic [7:0]  REG_BOOST     = 8'h08;
    localparam logic [7:0]  REG_SRV_PER   = 8'h0C;
    localparam logic [7:0]  REG_SRV_WID   = 8'h10;
    localparam logic [7:0]  REG_STATUS    = 8'h14;

    // Field positions
    localparam int          CTRL_DIR_LSB  = 0;
    localparam int          CTRL_SRV_EN   = 2;
    localparam int          BOOST_DUTY_LSB = 0;
    localparam int          BOOST_PER_LSB = 8;
    localparam int          STAT_STATE_LSB = 0;
    localparam int          STAT_BOOST    = 2;
    localparam int          STAT_SRV      = 3;

    // Fixed-frequency bridge PWM: counter runs 0..PWM_TOP
    localparam int          PWM_W         = 8;
    localparam logic [7:0]  PWM_TOP       = 8'hFE;
    localparam int          BPER_W        = 16;

    // Reset values
    localparam logic [2:0]  CTRL_RST      = 3'h0;
    localparam logic [7:0]  DUTY_RST      = 8'h00;
    localparam logic [7:0]  BOOST_DUTY_RST = 8'hFF;
    localparam logic [15:0] BOOST_PER_RST = 16'h0010;

    // Free-run pause on reversal, least time, rounded up
    localparam int          DEAD_NS       = 20;
    localparam int          DEAD_CYC_I    = (DEAD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [3:0]  DEAD_CYC      = 4'(DEAD_CYC_I < 1 ? 1 : DEAD_CYC_I);

    // Servo timing in microseconds and clock cycles
    localparam int          SRV_W         = 20;
    localparam int          SRV_PERIOD_US = 20000;
    localparam int          SRV_MIN_US    = 1000;
    localparam int          SRV_NEUTRAL_US = 1500;
    localparam int          SRV_MAX_US    = 2000;
    localparam int          SRV_CR_A_US   = 1300;
    localparam int          SRV_CR_B_US   = 1700;
    localparam logic [19:0] SRV_PERIOD_CYC = 20'(SRV_PERIOD_US * 1000 / CLK_PERIOD_NS);
    localparam logic [19:0] SRV_MIN_CYC   = 20'(SRV_MIN_US * 1000 / CLK_PERIOD_NS);
    localparam logic [19:0] SRV_NEUTRAL_CYC = 20'(SRV_NEUTRAL_US * 1000 / CLK_PERIOD_NS);
    localparam logic [19:0] SRV_MAX_CYC   = 20'(SRV_MAX_US * 1000 / CLK_PERIOD_NS);
    localparam logic [19:0] SRV_CR_A_CYC  = 20'(SRV_CR_A_US * 1000 / CLK_PERIOD_NS);
    localparam logic [19:0] SRV_CR_B_CYC  = 20'(SRV_CR_B_US * 1000 / CLK_PERIOD_NS);

    typedef enum logic [1:0] {
        ST_FREE = 2'b00,
        ST_CW   = 2'b01,
        ST_CCW  = 2'b10
    } hbd_state_t;
endpackage

// ### hbd_servo_timer.sv
`timescale 1ns/1ps
`default_nettype none
module hbd_servo_timer
    import hbd_pkg::*;
(
    input  wire logic             ref_clk_in,
    input  wire logic             rst_n_in,
    input  wire logic             ce_in,
    input  wire logic             en_in,
    input  wire logic [SRV_W-1:0] period_in,
    input  wire logic [SRV_W-1:0] width_in,
    output logic                  pulse_out
);
    logic [SRV_W-1:0] cnt;
    logic [SRV_W-1:0] width_q;
    logic [SRV_W-1:0] next_cnt;
    logic [SRV_W-1:0] next_width_q;
    logic             next_pulse;

    // Width is sampled once per frame so a write never splits a pulse
    always_comb begin
        next_cnt     = cnt + 20'h00001;
        next_width_q = width_q;
        if (!en_in) begin
            // Parked on the last count so enabling always opens a whole frame
            next_cnt = period_in - 20'h00001;
        end else if (cnt >= period_in - 20'h00001) begin
            next_cnt = '0;
        end
        if (next_cnt == '0) begin
            if (width_in < SRV_MIN_CYC) begin
                next_width_q = SRV_MIN_CYC;
            end else if (width_in > SRV_MAX_CYC) begin
                next_width_q = SRV_MAX_CYC;
            end else begin
                next_width_q = width_in;
            end
        end
        next_pulse = en_in && (next_cnt < next_width_q);
    end

    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            cnt       <= '0;
            width_q   <= SRV_NEUTRAL_CYC;
            pulse_out <= 1'b0;
        end else if (ce_in) begin
            cnt       <= next_cnt;
            width_q   <= next_width_q;
            pulse_out <= next_pulse;
        end
    end
endmodule
`default_nettype wire

// ### hbd_drive.sv
// Contract
// - Clockwise: forward pair on, reverse off
// - Counterclockwise: reverse pair on, forward off
// - Free-run: all four switches off
// - Never both switches of one half-bridge
// - Speed by PWM, fixed period, variable duty
// - Average voltage follows programmed duty
// - Forward pair high-side PWM, reverse low-side
// - Start with high duty, then requested duty
// - Gate driver input passes through unchanged
// - Upper/lower polarity handled by driver channels
// - Servo pulse repeats, width sets position
// - 1.5 ms width is servo neutral
// - Continuous servo: neutral stops, 1.3/1.7 full
// - Servo from separate timer, not bridge PWM
`timescale 1ns/1ps
`default_nettype none
module hbd_drive
    import hbd_pkg::*;
#(
    parameter logic [SRV_W-1:0] SRV_PERIOD_RST = SRV_PERIOD_CYC,
    parameter logic [SRV_W-1:0] SRV_WIDTH_RST  = SRV_NEUTRAL_CYC
)(
    input  wire logic              ref_clk_in,
    input  wire logic              rst_n_in,
    input  wire logic              ce_in,
    input  wire logic [ADDR_W-1:0] s_axi_awaddr_in,
    input  wire logic              s_axi_awvalid_in,
    output logic                   s_axi_awready_out,
    input  wire logic [DATA_W-1:0] s_axi_wdata_in,
    input  wire logic [3:0]        s_axi_wstrb_in,
    input  wire logic              s_axi_wvalid_in,
    output logic                   s_axi_wready_out,
    output logic [1:0]             s_axi_bresp_out,
    output logic                   s_axi_bvalid_out,
    input  wire logic              s_axi_bready_in,
    input  wire logic [ADDR_W-1:0] s_axi_araddr_in,
    input  wire logic              s_axi_arvalid_in,
    output logic                   s_axi_arready_out,
    output logic [DATA_W-1:0]      s_axi_rdata_out,
    output logic [1:0]             s_axi_rresp_out,
    output logic                   s_axi_rvalid_out,
    input  wire logic              s_axi_rready_in,
    output logic                   pwm_high_side_out,
    output logic                   pwm_low_side_out,
    output logic                   fwd_switch_upper_out,
    output logic                   fwd_switch_lower_out,
    output logic                   rev_switch_upper_out,
    output logic                   rev_switch_lower_out,
    output logic                   servo_pulse_out
);
    // Register file and bus state
    logic [2:0]        ctrl;
    logic [7:0]        duty;
    logic [23:0]       boost;
    logic [SRV_W-1:0]  srv_per;
    logic [SRV_W-1:0]  srv_wid;
    logic              aw_got;
    logic              w_got;
    logic [ADDR_W-1:0] awaddr_q;
    logic [DATA_W-1:0] wdata_q;
    logic [3:0]        wstrb_q;
    logic [2:0]        next_ctrl;
    logic [7:0]        next_duty;
    logic [23:0]       next_boost;
    logic [SRV_W-1:0]  next_srv_per;
    logic [SRV_W-1:0]  next_srv_wid;
    logic              next_aw_got;
    logic              next_w_got;
    logic [ADDR_W-1:0] next_awaddr_q;
    logic [DATA_W-1:0] next_wdata_q;
    logic [3:0]        next_wstrb_q;
    logic              next_awready;
    logic              next_wready;
    logic              next_bvalid;
    logic [1:0]        next_bresp;
    logic              next_arready;
    logic              next_rvalid;
    logic [DATA_W-1:0] next_rdata;
    logic [1:0]        next_rresp;
    hbd_state_t        state;
    hbd_state_t        next_state;
    logic [3:0]        gap;
    logic [3:0]        next_gap;
    logic [BPER_W-1:0] boost_left;
    logic [BPER_W-1:0] next_boost_left;
    logic [PWM_W-1:0]  pwm_cnt;
    logic [PWM_W-1:0]  next_pwm_cnt;
    logic [PWM_W-1:0]  eff_duty;
    logic              pwm_on;
    logic              next_fwd;
    logic              next_rev;
    logic [1:0]        req_dir;
    function automatic logic [DATA_W-1:0] merge(input logic [DATA_W-1:0] old,
                                                 input logic [DATA_W-1:0] wd,
                                                 input logic [3:0]        be);
        logic [DATA_W-1:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[i*8 +: 8] = wd[i*8 +: 8];
            end
        end
        return r;
    endfunction
    always_comb begin
        next_ctrl     = ctrl;
        next_duty     = duty;
        next_boost    = boost;
        next_srv_per  = srv_per;
        next_srv_wid  = srv_wid;
        next_aw_got   = aw_got;
        next_w_got    = w_got;
        next_awaddr_q = awaddr_q;
        next_wdata_q  = wdata_q;
        next_wstrb_q  = wstrb_q;
        next_awready  = s_axi_awready_out;
        next_wready   = s_axi_wready_out;
        next_bvalid   = s_axi_bvalid_out;
        next_bresp    = s_axi_bresp_out;
        next_arready  = s_axi_arready_out;
        next_rvalid   = s_axi_rvalid_out;
        next_rdata    = s_axi_rdata_out;
        next_rresp    = s_axi_rresp_out;
        if (s_axi_awvalid_in && s_axi_awready_out) begin
            next_aw_got   = 1'b1;
            next_awaddr_q = s_axi_awaddr_in;
            next_awready  = 1'b0;
        end
        if (s_axi_wvalid_in && s_axi_wready_out) begin
            next_w_got   = 1'b1;
            next_wdata_q = s_axi_wdata_in;
            next_wstrb_q = s_axi_wstrb_in;
            next_wready  = 1'b0;
        end
        if (aw_got && w_got && !s_axi_bvalid_out) begin
            next_aw_got = 1'b0;
            next_w_got  = 1'b0;
            next_bvalid = 1'b1;
            next_bresp  = RESP_OKAY;
            unique case ({awaddr_q[7:2], 2'b00})
                REG_CTRL:    next_ctrl = 3'(merge(32'(ctrl), wdata_q, wstrb_q));
                REG_DUTY:    next_duty = 8'(merge(32'(duty), wdata_q, wstrb_q));
                REG_BOOST:   next_boost = 24'(merge(32'(boost), wdata_q, wstrb_q));
                REG_SRV_PER: next_srv_per = 20'(merge(32'(srv_per), wdata_q, wstrb_q));
                REG_SRV_WID: next_srv_wid = 20'(merge(32'(srv_wid), wdata_q, wstrb_q));
                REG_STATUS:  next_bresp = RESP_OKAY;
                default:     next_bresp = RESP_SLVERR;
            endcase
        end
        if (s_axi_bvalid_out && s_axi_bready_in) begin
            next_bvalid  = 1'b0;
            next_awready = 1'b1;
            next_wready  = 1'b1;
        end
        if (s_axi_arvalid_in && s_axi_arready_out) begin
            next_arready = 1'b0;
            next_rvalid  = 1'b1;
            next_rresp   = RESP_OKAY;
            next_rdata   = '0;
            unique case ({s_axi_araddr_in[7:2], 2'b00})
                REG_CTRL:    next_rdata = 32'(ctrl);
                REG_DUTY:    next_rdata = 32'(duty);
                REG_BOOST:   next_rdata = 32'(boost);
                REG_SRV_PER: next_rdata = 32'(srv_per);
                REG_SRV_WID: next_rdata = 32'(srv_wid);
                REG_STATUS:  next_rdata = 32'({servo_pulse_out, (boost_left != '0), state});
                default:     next_rresp = RESP_SLVERR;
            endcase
        end else if (s_axi_rvalid_out && s_axi_rready_in) begin
            next_rvalid  = 1'b0;
            next_arready = 1'b1;
        end
    end
    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            ctrl              <= CTRL_RST;
            duty              <= DUTY_RST;
            boost             <= {BOOST_PER_RST, BOOST_DUTY_RST};
            srv_per           <= SRV_PERIOD_RST;
            srv_wid           <= SRV_WIDTH_RST;
            aw_got            <= 1'b0;
            w_got             <= 1'b0;
            awaddr_q          <= '0;
            wdata_q           <= '0;
            wstrb_q           <= '0;
            s_axi_awready_out <= 1'b1;
            s_axi_wready_out  <= 1'b1;
            s_axi_bvalid_out  <= 1'b0;
            s_axi_bresp_out   <= RESP_OKAY;
            s_axi_arready_out <= 1'b1;
            s_axi_rvalid_out  <= 1'b0;
            s_axi_rdata_out   <= '0;
            s_axi_rresp_out   <= RESP_OKAY;
        end else if (ce_in) begin
            ctrl              <= next_ctrl;
            duty              <= next_duty;
            boost             <= next_boost;
            srv_per           <= next_srv_per;
            srv_wid           <= next_srv_wid;
            aw_got            <= next_aw_got;
            w_got             <= next_w_got;
            awaddr_q          <= next_awaddr_q;
            wdata_q           <= next_wdata_q;
            wstrb_q           <= next_wstrb_q;
            s_axi_awready_out <= next_awready;
            s_axi_wready_out  <= next_wready;
            s_axi_bvalid_out  <= next_bvalid;
            s_axi_bresp_out   <= next_bresp;
            s_axi_arready_out <= next_arready;
            s_axi_rvalid_out  <= next_rvalid;
            s_axi_rdata_out   <= next_rdata;
            s_axi_rresp_out   <= next_rresp;
        end
    end
    // Direction, boost and PWM; any change of direction goes via free-run
    always_comb begin
        req_dir         = ctrl[CTRL_DIR_LSB +: 2];
        next_state      = state;
        next_gap        = (gap != '0) ? gap - 4'h1 : gap;
        next_boost_left = boost_left;
        next_pwm_cnt    = (pwm_cnt >= PWM_TOP) ? '0 : pwm_cnt + 8'h01;
        if (pwm_cnt >= PWM_TOP && boost_left != '0) begin
            next_boost_left = boost_left - 16'h0001;
        end
        unique case (state)
            ST_FREE: begin
                if (gap == '0 && (req_dir == 2'(ST_CW) || req_dir == 2'(ST_CCW))) begin
                    next_state      = hbd_state_t'(req_dir);
                    next_boost_left = boost[BOOST_PER_LSB +: BPER_W];
                end
            end
            ST_CW, ST_CCW: begin
                if (req_dir != 2'(state)) begin
                    next_state      = ST_FREE;
                    next_gap        = DEAD_CYC;
                    next_boost_left = '0;
                end
            end
            default: next_state = ST_FREE;
        endcase
        // Boost only ever raises the duty, never lowers a high request
        if (boost_left != '0 && boost[BOOST_DUTY_LSB +: 8] > duty) begin
            eff_duty = boost[BOOST_DUTY_LSB +: 8];
        end else begin
            eff_duty = duty;
        end
        pwm_on   = pwm_cnt < eff_duty;
        next_fwd = (state == ST_CW) && pwm_on;
        next_rev = (state == ST_CCW) && pwm_on;
    end
    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            state                <= ST_FREE;
            gap                  <= '0;
            boost_left           <= '0;
            pwm_cnt              <= '0;
            pwm_high_side_out    <= 1'b0;
            pwm_low_side_out     <= 1'b0;
            fwd_switch_upper_out <= 1'b0;
            fwd_switch_lower_out <= 1'b0;
            rev_switch_upper_out <= 1'b0;
            rev_switch_lower_out <= 1'b0;
        end else if (ce_in) begin
            state                <= next_state;
            gap                  <= next_gap;
            boost_left           <= next_boost_left;
            pwm_cnt              <= next_pwm_cnt;
            pwm_high_side_out    <= next_fwd;
            pwm_low_side_out     <= next_rev;
            // 1 means switch on; the driver's inverting channel serves the P-side
            fwd_switch_upper_out <= next_fwd;
            fwd_switch_lower_out <= next_fwd;
            rev_switch_upper_out <= next_rev;
            rev_switch_lower_out <= next_rev;
        end
    end
    hbd_servo_timer u_servo (
        .ref_clk_in (ref_clk_in),
        .rst_n_in   (rst_n_in),
        .ce_in      (ce_in),
        .en_in      (ctrl[CTRL_SRV_EN]),
        .period_in  (srv_per),
        .width_in   (srv_wid),
        .pulse_out  (servo_pulse_out)
    );
    default clocking cb @(posedge ref_clk_in);
    endclocking
    default disable iff (!rst_n_in || !ce_in);
    sequence s_enter_dir;
        state == ST_FREE ##1 (state == ST_CW || state == ST_CCW);
    endsequence
    sequence s_fwd_live;
        fwd_switch_upper_out;
    endsequence

    property p_no_overlap;
        !((fwd_switch_upper_out || fwd_switch_lower_out) &&
          (rev_switch_upper_out || rev_switch_lower_out));
    endproperty
    a_no_overlap: assert property (p_no_overlap) else $error("bridge pairs overlap");
    property p_cw;
        state == ST_CW |=> !rev_switch_upper_out && !rev_switch_lower_out &&
                           fwd_switch_upper_out == fwd_switch_lower_out;
    endproperty
    a_cw: assert property (p_cw) else $error("clockwise pair wrong");
    property p_ccw;
        state == ST_CCW |=> !fwd_switch_upper_out && !fwd_switch_lower_out &&
                            rev_switch_upper_out == rev_switch_lower_out;
    endproperty
    a_ccw: assert property (p_ccw) else $error("counterclockwise pair wrong");
    property p_free;
        state == ST_FREE |=> !(fwd_switch_upper_out || fwd_switch_lower_out ||
                               rev_switch_upper_out || rev_switch_lower_out);
    endproperty
    a_free: assert property (p_free) else $error("switch on in free-run");
    property p_reverse_gap;
        s_fwd_live |=> !rev_switch_upper_out ##1 !rev_switch_upper_out;
    endproperty
    a_reverse_gap: assert property (p_reverse_gap) else $error("no free-run gap");
    property p_pin_map;
        pwm_high_side_out == fwd_switch_upper_out && pwm_low_side_out == rev_switch_lower_out;
    endproperty
    a_pin_map: assert property (p_pin_map) else $error("pwm pin to pair mismatch");
    property p_period;
        pwm_cnt == PWM_TOP |=> pwm_cnt == '0;
    endproperty
    a_period: assert property (p_period) else $error("pwm period not fixed");
    property p_duty;
        state == ST_CW && $stable(state) |=> fwd_switch_upper_out == $past(pwm_on);
    endproperty
    a_duty: assert property (p_duty) else $error("output not following duty");
    property p_boost;
        s_enter_dir |-> boost_left == $past(boost[BOOST_PER_LSB +: BPER_W]);
    endproperty
    a_boost: assert property (p_boost) else $error("boost not started");
endmodule
`default_nettype wire

// ### hbd_motor_model.sv
`timescale 1ns/1ps
`default_nettype none
module hbd_motor_model (
    input  wire logic ref_clk_in,
    input  wire logic fu_in,
    input  wire logic fl_in,
    input  wire logic ru_in,
    input  wire logic rl_in,
    output int        shorts_out,
    output int        direct_rev_out,
    output int        pair_err_out
);
    // Upper switches are P-channel, so their driver channel inverts
    logic fu_gate_n;
    logic ru_gate_n;
    logic prev_fwd;
    logic prev_rev;
    assign fu_gate_n = ~fu_in;
    assign ru_gate_n = ~ru_in;
    initial begin
        shorts_out = 0;
        direct_rev_out = 0;
        pair_err_out = 0;
        prev_fwd = 1'b0;
        prev_rev = 1'b0;
    end
    // Each leg holds one forward and one reverse switch
    always @(posedge ref_clk_in) begin
        if ((!fu_gate_n && rl_in) || (!ru_gate_n && fl_in))
            shorts_out++;
        if (((fu_in || fl_in) && prev_rev) || ((ru_in || rl_in) && prev_fwd))
            direct_rev_out++;
        if (fu_in !== fl_in || ru_in !== rl_in)
            pair_err_out++;
        prev_fwd <= fu_in || fl_in;
        prev_rev <= ru_in || rl_in;
    end
endmodule
`default_nettype wire

// ### hbd_drive_bench.sv
`timescale 1ns/1ps
`default_nettype none
module hbd_drive_bench;
    import hbd_pkg::*;
    logic clk = 1'b0, rst_n = 1'b0, ce = 1'b1;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata;
    logic awv = 1'b0, wv = 1'b0, bready = 1'b0, arv = 1'b0, rready = 1'b0;
    logic awr, wr, bv, arr, rv, hi, lo, fu, fl, ru, rl, srv;
    logic [1:0] bresp, rresp;
    int failures = 0, tests_run = 0, seed = 16243, shorts, drev, perr, d, k;
    int exp_reg [6] = '{0, 0, 32'h10FF, 60000, int'(SRV_NEUTRAL_CYC), 0};
    int run_hi = 0, run_lo = 0, len_hi = 0, len_lo = 0;
    logic [31:0] v;
    logic [1:0] r;
    initial forever #10 clk = ~clk;
    hbd_drive #(.SRV_PERIOD_RST(20'd60000), .SRV_WIDTH_RST(SRV_NEUTRAL_CYC)) u_hbd_drive (
        .ref_clk_in(clk), .rst_n_in(rst_n), .ce_in(ce),
        .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awv), .s_axi_awready_out(awr),
        .s_axi_wdata_in(wdata), .s_axi_wstrb_in(4'hF), .s_axi_wvalid_in(wv),
        .s_axi_wready_out(wr), .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bv),
        .s_axi_bready_in(bready), .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arv),
        .s_axi_arready_out(arr), .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp),
        .s_axi_rvalid_out(rv), .s_axi_rready_in(rready),
        .pwm_high_side_out(hi), .pwm_low_side_out(lo),
        .fwd_switch_upper_out(fu), .fwd_switch_lower_out(fl),
        .rev_switch_upper_out(ru), .rev_switch_lower_out(rl), .servo_pulse_out(srv));
    hbd_motor_model u_hbd_motor_model (.ref_clk_in(clk), .fu_in(fu), .fl_in(fl),
        .ru_in(ru), .rl_in(rl), .shorts_out(shorts), .direct_rev_out(drev),
        .pair_err_out(perr));
    // Length of each finished high and low stretch of the servo pin
    always @(posedge clk) begin
        run_hi <= srv ? run_hi + 1 : 0;
        run_lo <= srv ? 0 : run_lo + 1;
        if (srv && run_lo != 0) len_lo <= run_lo;
        if (!srv && run_hi != 0) len_hi <= run_hi;
    end
    task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            failures++;
            $display("wrong value at %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
        chk_val({30'h0, got}, {30'h0, exp});
    endtask
    // Address and data are offered together; each drops once taken
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] dt);
        awaddr <= a; wdata <= dt; awv <= 1'b1; wv <= 1'b1; bready <= 1'b1;
        while (!bv) begin
            @(posedge clk);
            if (awr && awv) awv <= 1'b0;
            if (wr && wv) wv <= 1'b0;
        end
        r = bresp;
        bready <= 1'b0;
        @(posedge clk);
    endtask
    task automatic axi_rd(input logic [7:0] a);
        araddr <= a; arv <= 1'b1; rready <= 1'b1;
        @(posedge clk);
        while (!arr) @(posedge clk);
        arv <= 1'b0;
        while (!rv) @(posedge clk);
        v = rdata;
        r = rresp;
        rready <= 1'b0;
        @(posedge clk);
    endtask
    task automatic count_hi(input int which, input int n);
        k = 0;
        repeat (n) begin
            @(posedge clk);
            #1;
            k += (which == 0) ? int'(hi) : int'(lo);
        end
    endtask
    task automatic stop_test;
        $display("comparisons %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    initial begin
        #(90000 * CLK_PERIOD_NS);
        failures++;
        stop_test();
    end
    initial begin
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        for (int i = 0; i < 6; i++) begin
            axi_rd(8'(4 * i));
            chk_val(v, exp_reg[i]);
        end
        axi_rd(8'h18);
        chk_resp(r, RESP_SLVERR);
        chk_val(v, 32'h0);
        axi_wr(8'h18, 32'h5);
        chk_resp(r, RESP_SLVERR);
        $display("test registers done");
        d = 1 + ($unsigned($random(seed)) % 254);
        axi_wr(REG_DUTY, 32'(d));
        axi_wr(REG_BOOST, 32'h0003FF);
        axi_wr(REG_CTRL, 32'h1);
        for (int t = 0; t < 600 && !hi; t++) @(posedge clk);
        count_hi(0, 255);
        chk_val(32'(k), 32'd255);
        repeat (4 * 255) @(posedge clk);
        count_hi(0, 255);
        chk_val(32'(k), 32'(d));
        ce <= 1'b0;
        v = {31'h0, hi};
        count_hi(0, 255);
        chk_val(32'(k), v * 32'd255);
        ce <= 1'b1;
        axi_rd(REG_STATUS);
        chk_val(v & 32'h3, 32'h1);
        axi_wr(REG_CTRL, 32'h2);
        repeat (6 * 255) @(posedge clk);
        count_hi(1, 255);
        chk_val(32'(k), 32'(d));
        count_hi(0, 255);
        chk_val(32'(k), 32'h0);
        axi_wr(REG_CTRL, 32'h3);
        count_hi(1, 300);
        chk_val(32'(k), 32'h0);
        chk_val(32'(shorts), 32'h0);
        chk_val(32'(drev), 32'h0);
        chk_val(32'(perr), 32'h0);
        $display("test bridge done");
        axi_wr(REG_SRV_PER, 32'd70000);
        axi_wr(REG_SRV_WID, 32'(SRV_CR_A_CYC));
        axi_rd(REG_SRV_PER);
        chk_val(v, 32'd70000);
        axi_rd(REG_SRV_WID);
        chk_val(v, 32'(SRV_CR_A_CYC));
        axi_wr(REG_CTRL, 32'h4);
        for (int t = 0; t < 70000 && !srv; t++) begin @(posedge clk); #1; end
        for (int t = 0; t < 70000 && srv; t++) begin @(posedge clk); #1; end
        repeat (2) @(posedge clk);
        chk_val(32'(len_hi), 32'(SRV_CR_A_CYC));
        for (int t = 0; t < 70000 && !srv; t++) begin @(posedge clk); #1; end
        repeat (2) @(posedge clk);
        chk_val(32'(len_lo), 32'd5000);
        $display("test servo done");
        stop_test();
    end
endmodule
`default_nettype wire
